// ==== fem_monitor.v ====
// Fault, supply, wake-up and thermal event monitor with AXI4-Lite registers
`timescale 1ns/1ps
`include "fem_map.vh"

module fem_monitor #(
  parameter NIRQ = 6
) (
  input wire clk,
  input wire rst,
  // Pins and analog comparators, asynchronous
  input wire serial_sel,
  input wire limit_select_pin,
  input wire line_short,
  input wire driver_hot,
  input wire field_below_16v,
  input wire field_below_7v4,
  input wire temp_above_140,
  input wire temp_below_125,
  input wire die_above_165,
  input wire rail_5v_ok,
  input wire logic_rail_ok,
  input wire rail_3v3_ok,
  input wire internal_5v_used,
  // Control outputs
  output reg fault_irq_n,
  output reg wake_pulse_n,
  output reg driver_en,
  output reg ldo5_on,
  output reg ldo3_on,
  output reg [1:0] limit_code,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // ==========================================================
  // Input synchronisers
  localparam NSYNC = 13;
  wire [NSYNC-1:0] raw_in;
  reg [NSYNC-1:0] sync1_r;
  reg [NSYNC-1:0] sync2_r;

  assign raw_in = {internal_5v_used, rail_3v3_ok, logic_rail_ok, rail_5v_ok,
                   die_above_165, temp_below_125, temp_above_140,
                   field_below_7v4, field_below_16v, driver_hot, line_short,
                   limit_select_pin, serial_sel};

  always @(posedge clk) begin
    if (rst) begin
      sync1_r <= {NSYNC{1'b0}};
      sync2_r <= {NSYNC{1'b0}};
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  wire serial_mode = sync2_r[0];
  wire lim_pin_s = sync2_r[1];
  wire short_s = sync2_r[2];
  wire hot_s = sync2_r[3];
  wire below16_s = sync2_r[4];
  wire below7_s = sync2_r[5];
  wire above140_s = sync2_r[6];
  wire below125_s = sync2_r[7];
  wire above165_s = sync2_r[8];
  wire v5_ok_s = sync2_r[9];
  wire vl_ok_s = sync2_r[10];
  wire v33_ok_s = sync2_r[11];
  wire int5v_s = sync2_r[12];

  // ==========================================================
  // Configuration registers
  reg [2:0] mode_r;
  reg [3:0] current_limit_reg_r;
  reg [NIRQ-1:0] irq_r;
  reg thermal_r;
  reg restart_rst_r;

  wire wake_detect_off = mode_r[`FEM_B_WAKE_OFF];
  wire supply_low_warn_en = mode_r[`FEM_B_WARN_EN];
  wire ldo3_off = mode_r[`FEM_B_LDO3_OFF];
  wire limit_select_hi = current_limit_reg_r[`FEM_B_LIM_HI];
  wire limit_select_lo = current_limit_reg_r[`FEM_B_LIM_LO];
  wire blanking_select_hi = current_limit_reg_r[`FEM_B_BLANK_HI];
  wire blanking_select_lo = current_limit_reg_r[`FEM_B_BLANK_LO];

  // ==========================================================
  // Blanking time and short-circuit timer
  reg [31:0] blank_cyc;
  reg [11:0] short_cnt_r;
  reg short_d_r;

  always @* begin
    if (!serial_mode) begin
      blank_cyc = `FEM_BLANK1_CYC;
    end else begin
      case ({blanking_select_hi, blanking_select_lo})
        2'h0: blank_cyc = `FEM_BLANK0_CYC;
        2'h1: blank_cyc = `FEM_BLANK1_CYC;
        2'h2: blank_cyc = `FEM_BLANK2_CYC;
        default: blank_cyc = `FEM_BLANK3_CYC;
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      short_cnt_r <= 12'h000;
      short_d_r <= 1'b0;
    end else begin
      short_d_r <= short_s;
      if (!short_s) begin
        short_cnt_r <= 12'h000;
      end else if (short_cnt_r != 12'hFFF) begin
        short_cnt_r <= short_cnt_r + 12'h001;
      end
    end
  end

  // Short past blanking or overheating counts as a line fault
  wire line_fault_cond = (short_s && (short_cnt_r >= blank_cyc)) || hot_s;
  wire line_fault_live = line_fault_cond;

  // ==========================================================
  // Wake-up detection and pulse
  wire wake_allowed = !serial_mode || !wake_detect_off;
  // Short ended after wake time but before blanking expired
  wire wake_event = wake_allowed && short_d_r && !short_s &&
                    (short_cnt_r >= `FEM_WAKE_CYC) &&
                    (short_cnt_r < blank_cyc);
  localparam [31:0] PULSE_LOAD = `FEM_PULSE_CYC - 1;
  reg [11:0] pulse_cnt_r;

  always @(posedge clk) begin
    if (rst) begin
      pulse_cnt_r <= 12'h000;
      wake_pulse_n <= 1'b1;
    end else if (wake_event) begin
      pulse_cnt_r <= PULSE_LOAD[11:0];
      wake_pulse_n <= 1'b0;
    end else if (pulse_cnt_r != 12'h000) begin
      pulse_cnt_r <= pulse_cnt_r - 12'h001;
    end else begin
      wake_pulse_n <= 1'b1;
    end
  end

  // ==========================================================
  // Supply, temperature and thermal status
  reg supply_low_warn;
  reg supply_undervolt;
  reg overtemp_warn;
  reg pwrup_done_r;

  always @(posedge clk) begin
    if (rst) begin
      supply_low_warn <= 1'b0;
      supply_undervolt <= 1'b0;
      overtemp_warn <= 1'b0;
      thermal_r <= 1'b0;
      pwrup_done_r <= 1'b0;
    end else begin
      supply_low_warn <= serial_mode && below16_s;
      supply_undervolt <= serial_mode && below7_s;
      if (!serial_mode) begin
        overtemp_warn <= 1'b0;
      end else if (above140_s) begin
        overtemp_warn <= 1'b1;
      end else if (below125_s) begin
        overtemp_warn <= 1'b0;
      end
      thermal_r <= above165_s;
      if (!below7_s && v5_ok_s && vl_ok_s && v33_ok_s) begin
        pwrup_done_r <= 1'b1;
      end
    end
  end

  wire thermal_off = serial_mode && thermal_r;

  // Delayed copies for event edges
  reg [4:0] live_d_r;
  wire [4:0] live_now = {thermal_off, overtemp_warn, supply_undervolt,
                         supply_low_warn, serial_mode && line_fault_live};
  wire [4:0] live_rise = live_now & ~live_d_r;

  always @(posedge clk) begin
    if (rst) begin
      live_d_r <= 5'h00;
    end else begin
      live_d_r <= live_now;
    end
  end

  // ==========================================================
  // Latched interrupt bits, set wins over read clear
  wire rd_take = s_axi_arready && s_axi_arvalid;
  wire int_read = rd_take && (s_axi_araddr[3:2] == `FEM_INTERRUPT_OFS >> 2);
  wire [NIRQ-1:0] irq_set;

  assign irq_set[`FEM_B_LINE_FAULT] = live_rise[0];
  assign irq_set[`FEM_B_LOW_WARN] = live_rise[1] && supply_low_warn_en;
  assign irq_set[`FEM_B_UNDERVOLT] = live_rise[2];
  assign irq_set[`FEM_B_OVERTEMP] = live_rise[3];
  assign irq_set[`FEM_B_THERMAL] = live_rise[4];
  assign irq_set[`FEM_B_WAKE] = wake_event && serial_mode;

  genvar gi;
  generate
    for (gi = 0; gi < NIRQ; gi = gi + 1) begin : g_irq
      always @(posedge clk) begin
        if (rst || restart_rst_r) begin
          irq_r[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_r[gi] <= 1'b1;
        end else if (int_read) begin
          irq_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  wire line_fault_latched = irq_r[`FEM_B_LINE_FAULT];

  // ==========================================================
  // Outputs to pins and analog
  always @(posedge clk) begin
    if (rst) begin
      fault_irq_n <= 1'b1;
      driver_en <= 1'b0;
      ldo5_on <= 1'b0;
      ldo3_on <= 1'b0;
      limit_code <= `FEM_LIM_PIN_LOW;
      restart_rst_r <= 1'b0;
    end else begin
      if (serial_mode) begin
        fault_irq_n <= ~(|irq_r);
        limit_code <= {limit_select_hi, limit_select_lo};
      end else begin
        fault_irq_n <= ~line_fault_cond;
        limit_code <= lim_pin_s ? `FEM_LIM_PIN_HIGH
                                : `FEM_LIM_PIN_LOW;
      end
      driver_en <= pwrup_done_r && !thermal_r && !below7_s &&
                   v5_ok_s && vl_ok_s;
      ldo5_on <= !thermal_r;
      ldo3_on <= !thermal_r && !(serial_mode && ldo3_off);
      // Cooling with internal 5V resets registers to defaults
      restart_rst_r <= thermal_r && !above165_s && int5v_s;
    end
  end

  // ==========================================================
  // AXI4-Lite write channel
  reg aw_held_r;
  reg w_held_r;
  reg [3:0] awaddr_r;
  reg [3:0] wdata_r;
  reg wstrb0_r;

  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FEM_RESP_OKAY;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 4'h0;
      wstrb0_r <= 1'b0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata[3:0];
        wstrb0_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_held_r && w_held_r && !s_axi_bvalid) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_r[3:2])
          `FEM_MODE_OFS >> 2: s_axi_bresp <= `FEM_RESP_OKAY;
          `FEM_CURRENT_LIMIT_REG_OFS >> 2: s_axi_bresp <= `FEM_RESP_OKAY;
          default: s_axi_bresp <= `FEM_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  wire wr_commit = aw_held_r && w_held_r && !s_axi_bvalid && wstrb0_r;

  always @(posedge clk) begin
    if (rst || restart_rst_r) begin
      mode_r <= `FEM_MODE_RST;
      current_limit_reg_r <= `FEM_CURRENT_LIMIT_REG_RST;
    end else if (wr_commit) begin
      if (awaddr_r[3:2] == `FEM_MODE_OFS >> 2) begin
        mode_r <= wdata_r[2:0];
      end
      if (awaddr_r[3:2] == `FEM_CURRENT_LIMIT_REG_OFS >> 2) begin
        current_limit_reg_r <= wdata_r;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel, served during thermal shutdown too
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (s_axi_araddr[3:2])
      `FEM_STATUS_OFS >> 2: begin
        rd_mux[`FEM_B_LINE_FAULT] = serial_mode && line_fault_live;
        rd_mux[`FEM_B_LOW_WARN] = supply_low_warn;
        rd_mux[`FEM_B_UNDERVOLT] = supply_undervolt;
        rd_mux[`FEM_B_OVERTEMP] = overtemp_warn;
        rd_mux[`FEM_B_THERMAL] = thermal_off;
        rd_mux[`FEM_B_SERIAL] = serial_mode;
        rd_mux[`FEM_B_DRIVER_ON] = driver_en;
      end
      `FEM_INTERRUPT_OFS >> 2: rd_mux[NIRQ-1:0] = irq_r;
      `FEM_MODE_OFS >> 2: rd_mux[2:0] = mode_r;
      default: rd_mux[3:0] = current_limit_reg_r;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FEM_RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= `FEM_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ==== fem_map.vh ====
// Register map, field positions, reset values and timing of the fault monitor
`ifndef FEM_MAP_VH
`define FEM_MAP_VH

// Register byte offsets
`define FEM_STATUS_OFS 4'h0
`define FEM_INTERRUPT_OFS 4'h4
`define FEM_MODE_OFS 4'h8
`define FEM_CURRENT_LIMIT_REG_OFS 4'hC

// Status and interrupt bit positions
`define FEM_B_LINE_FAULT 0
`define FEM_B_LOW_WARN 1
`define FEM_B_UNDERVOLT 2
`define FEM_B_OVERTEMP 3
`define FEM_B_THERMAL 4
`define FEM_B_WAKE 5
`define FEM_B_SERIAL 6
`define FEM_B_DRIVER_ON 7

// Mode register fields
`define FEM_B_WAKE_OFF 0
`define FEM_B_WARN_EN 1
`define FEM_B_LDO3_OFF 2

// Current-limit register fields
`define FEM_B_LIM_LO 0
`define FEM_B_LIM_HI 1
`define FEM_B_BLANK_LO 2
`define FEM_B_BLANK_HI 3

// Reset values and pin-mode limit codes
`define FEM_MODE_RST 3'h0
`define FEM_CURRENT_LIMIT_REG_RST 4'h5
`define FEM_LIM_PIN_LOW 2'h1
`define FEM_LIM_PIN_HIGH 2'h2

// Timing, in microseconds and derived clock cycles
`define FEM_CLK_MHZ 10
`define FEM_WAKE_US 80
`define FEM_PULSE_US 200
`define FEM_BLANK0_US 96
`define FEM_BLANK1_US 128
`define FEM_BLANK2_US 192
`define FEM_BLANK3_US 256
`define FEM_WAKE_CYC (`FEM_WAKE_US * `FEM_CLK_MHZ)
`define FEM_PULSE_CYC (`FEM_PULSE_US * `FEM_CLK_MHZ)
`define FEM_BLANK0_CYC (`FEM_BLANK0_US * `FEM_CLK_MHZ)
`define FEM_BLANK1_CYC (`FEM_BLANK1_US * `FEM_CLK_MHZ)
`define FEM_BLANK2_CYC (`FEM_BLANK2_US * `FEM_CLK_MHZ)
`define FEM_BLANK3_CYC (`FEM_BLANK3_US * `FEM_CLK_MHZ)

// AXI responses
`define FEM_RESP_OKAY 2'h0
`define FEM_RESP_SLVERR 2'h2

`endif

// ==== fem_chk_asserts.sv ====
// Port checker for the fault and event monitor
`timescale 1ns/1ps
`include "fem_map.vh"
module fem_chk (
  input wire clk,
  input wire rst,
  input wire serial_sel,
  input wire limit_select_pin,
  input wire line_short,
  input wire driver_hot,
  input wire field_below_7v4,
  input wire die_above_165,
  input wire rail_5v_ok,
  input wire logic_rail_ok,
  input wire fault_irq_n,
  input wire wake_pulse_n,
  input wire driver_en,
  input wire ldo5_on,
  input wire ldo3_on,
  input wire [1:0] limit_code,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready
);
  // ==========
  // Helpers
  reg [11:0] low_cnt_r;
  wire rd_irq;
  assign rd_irq = s_axi_arvalid && s_axi_arready &&
    s_axi_araddr[3:2] == 2'h1;
  always @(posedge clk) begin
    if (rst || wake_pulse_n)
      low_cnt_r <= 12'h000;
    else
      low_cnt_r <= low_cnt_r + 12'h001;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ==========
  // Checks
  chk_wake_len: assert property (
    $rose(wake_pulse_n) |-> low_cnt_r == 12'h7D0)
    else $error("wake pulse length wrong");
  chk_irq_hold: assert property (
    serial_sel[*5] ##0 $rose(fault_irq_n) |->
    $past(rd_irq) || $past(rd_irq, 2) || $past(rd_irq, 3))
    else $error("interrupt released without read");
  chk_pin_fault: assert property (
    (!serial_sel && driver_hot)[*5] |-> !fault_irq_n)
    else $error("pin fault output not asserted");
  chk_pin_clear: assert property (
    (!serial_sel && !driver_hot && !line_short)[*5] |-> fault_irq_n)
    else $error("pin fault output not released");
  chk_pin_limit: assert property (
    (!serial_sel && $stable(limit_select_pin))[*5] |-> limit_code ==
    (limit_select_pin ? `FEM_LIM_PIN_HIGH : `FEM_LIM_PIN_LOW))
    else $error("pin limit code wrong");
  chk_supply_off: assert property (
    (field_below_7v4 || !rail_5v_ok || !logic_rail_ok)[*4] |-> !driver_en)
    else $error("driver on with low supply");
  chk_thermal_off: assert property (
    die_above_165[*5] |-> !driver_en && !ldo5_on && !ldo3_on)
    else $error("outputs on in thermal shutdown");
  chk_wake_irq: assert property (
    serial_sel[*5] ##0 $fell(wake_pulse_n) |-> ##[0:3] !fault_irq_n)
    else $error("wake without interrupt");
  cov_wake: cover property ($fell(wake_pulse_n));
  cov_clear: cover property (rd_irq && !fault_irq_n);
  cov_thermal: cover property (die_above_165 && !driver_en);
endmodule
bind fem_monitor fem_chk i_chk (
  .clk, .rst, .serial_sel, .limit_select_pin, .line_short, .driver_hot,
  .field_below_7v4, .die_above_165, .rail_5v_ok, .logic_rail_ok,
  .fault_irq_n, .wake_pulse_n, .driver_en, .ldo5_on, .ldo3_on,
  .limit_code, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready
);

// ==== fem_host.sv ====
// Host model issuing register cycles to the fault monitor
`timescale 1ns/1ps
module fem_host (
  input wire clk,
  output reg [3:0] s_axi_awaddr,
  output reg s_axi_awvalid,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata,
  output reg [3:0] s_axi_wstrb,
  output reg s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  output reg s_axi_bready,
  output reg [3:0] s_axi_araddr,
  output reg s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready
);
  // ==========
  // Bus cycles
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = 41'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = 6'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
  end
  task write(input [3:0] a, input [31:0] d, output [1:0] r);
    reg done;
    begin
      done = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
        @(posedge clk);
        if (s_axi_awvalid && s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready)
          s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) begin
          r = s_axi_bresp;
          s_axi_bready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
  task read(input [3:0] a, output [31:0] d);
    reg done;
    begin
      done = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
        @(posedge clk);
        if (s_axi_arvalid && s_axi_arready)
          s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) begin
          d = s_axi_rdata;
          s_axi_rready <= 1'b0;
          done = 1'b1;
        end
      end
    end
  endtask
endmodule

// ==== fem_monitor_tb.sv ====
// Self-checking bench for the fault and event monitor
`timescale 1ns/1ps
`include "fem_map.vh"
module fem_monitor_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg serial_sel = 1'b0;
  reg limit_select_pin = 1'b0;
  reg line_short = 1'b0;
  reg driver_hot = 1'b0;
  reg field_below_16v = 1'b0;
  reg field_below_7v4 = 1'b0;
  reg temp_above_140 = 1'b0;
  reg temp_below_125 = 1'b1;
  reg die_above_165 = 1'b0;
  reg rail_5v_ok = 1'b1;
  reg logic_rail_ok = 1'b1;
  reg rail_3v3_ok = 1'b1;
  reg internal_5v_used = 1'b1;
  reg lclk_on = 1'b0;
  reg [1:0] lclk_cnt = 2'h0;
  wire fault_irq_n, wake_pulse_n, driver_en, ldo5_on, ldo3_on;
  wire [1:0] limit_code, s_axi_bresp, s_axi_rresp;
  wire [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  wire s_axi_rvalid, s_axi_rready;
  wire [31:0] pins;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer i;
  reg [31:0] v;
  reg [1:0] r;
  assign pins = {25'h0, fault_irq_n, wake_pulse_n, driver_en, ldo5_on,
    ldo3_on, limit_code};
  // ==========
  // Clocks and instances
  always #50 clk = ~clk;
  always @(posedge clk) begin
    lclk_cnt <= lclk_cnt + 2'h1;
    if (lclk_on && lclk_cnt == 2'h3)
      limit_select_pin <= ~limit_select_pin;
  end
  fem_monitor i_dut (.clk, .rst, .serial_sel, .limit_select_pin,
    .line_short, .driver_hot, .field_below_16v, .field_below_7v4,
    .temp_above_140, .temp_below_125, .die_above_165, .rail_5v_ok,
    .logic_rail_ok, .rail_3v3_ok, .internal_5v_used, .fault_irq_n,
    .wake_pulse_n, .driver_en, .ldo5_on, .ldo3_on, .limit_code,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  fem_host i_host (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  // ==========
  // Helpers
  function [31:0] pe(input irq_n, input drv, input ldo, input [1:0] lim);
    pe = {25'h0, irq_n, 1'b1, drv, ldo, ldo, lim};
  endfunction
  function [31:0] st(input drv, input [4:0] b);
    st = {24'h0, drv, 2'h2, b};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      i_host.read(a, v);
      chk(v, e);
      chk({30'h0, s_axi_rresp}, {30'h0, `FEM_RESP_OKAY});
    end
  endtask
  task wr(input [3:0] a, input [31:0] d, input [1:0] e);
    begin
      i_host.write(a, d, r);
      chk({30'h0, r}, {30'h0, e});
    end
  endtask
  task wake(input integer dur, input e);
    begin
      line_short <= 1'b1;
      wt(dur);
      line_short <= 1'b0;
      wt(10);
      chk({31'h0, wake_pulse_n}, {31'h0, ~e});
      wt(2100);
    end
  endtask
  task ev(input drv, input [4:0] s, input [5:0] q);
    begin
      wt(8);
      rd(`FEM_STATUS_OFS, st(drv, s));
      chk({31'h0, fault_irq_n}, {31'h0, q == 6'h00});
      rd(`FEM_INTERRUPT_OFS, {26'h0, q});
      wt(4);
      chk({31'h0, fault_irq_n}, 32'h1);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // ==========
  // Tests
  initial begin
    #3000000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
  initial begin
    i = $urandom(49161);
    wt(20);
    rst <= 1'b0;
    wt(10);
    chk(pins, pe(1'b1, 1'b1, 1'b1, `FEM_LIM_PIN_LOW));
    limit_select_pin <= 1'b1;
    temp_above_140 <= 1'b1;
    temp_below_125 <= 1'b0;
    field_below_16v <= 1'b1;
    wt(8);
    chk(pins, pe(1'b1, 1'b1, 1'b1, `FEM_LIM_PIN_HIGH));
    driver_hot <= 1'b1;
    wt(8);
    chk(pins, pe(1'b0, 1'b1, 1'b1, `FEM_LIM_PIN_HIGH));
    driver_hot <= 1'b0;
    temp_above_140 <= 1'b0;
    temp_below_125 <= 1'b1;
    field_below_16v <= 1'b0;
    wt(8);
    chk(pins, pe(1'b1, 1'b1, 1'b1, `FEM_LIM_PIN_HIGH));
    wake(850 + $urandom % 300, 1'b1);
    lclk_on <= 1'b1;
    serial_sel <= 1'b1;
    wt(8);
    i_host.read(`FEM_INTERRUPT_OFS, v);
    rd(`FEM_MODE_OFS, {29'h0, `FEM_MODE_RST});
    rd(`FEM_CURRENT_LIMIT_REG_OFS, {28'h0, `FEM_CURRENT_LIMIT_REG_RST});
    wr(`FEM_STATUS_OFS, 32'hFFFFFFFF, `FEM_RESP_SLVERR);
    for (i = 0; i < 4; i = i + 1) begin
      v = {28'h0, 2'($urandom % 4), 2'(i)};
      wr(`FEM_CURRENT_LIMIT_REG_OFS, v, `FEM_RESP_OKAY);
      wt(6);
      chk({30'h0, limit_code}, {30'h0, 2'(i)});
    end
    wr(`FEM_CURRENT_LIMIT_REG_OFS, 32'h1, `FEM_RESP_OKAY);
    wake(1100, 1'b0);
    ev(1'b1, 5'h00, 6'h01);
    wr(`FEM_CURRENT_LIMIT_REG_OFS, 32'h5, `FEM_RESP_OKAY);
    driver_hot <= 1'b1;
    wt(8);
    rd(`FEM_STATUS_OFS, st(1'b1, 5'h01));
    driver_hot <= 1'b0;
    ev(1'b1, 5'h00, 6'h01);
    field_below_16v <= 1'b1;
    ev(1'b1, 5'h02, 6'h00);
    field_below_16v <= 1'b0;
    wr(`FEM_MODE_OFS, 32'h2, `FEM_RESP_OKAY);
    field_below_16v <= 1'b1;
    ev(1'b1, 5'h02, 6'h02);
    field_below_16v <= 1'b0;
    field_below_7v4 <= 1'b1;
    ev(1'b0, 5'h04, 6'h04);
    field_below_7v4 <= 1'b0;
    temp_above_140 <= 1'b1;
    temp_below_125 <= 1'b0;
    ev(1'b1, 5'h08, 6'h08);
    temp_above_140 <= 1'b0;
    ev(1'b1, 5'h08, 6'h00);
    temp_below_125 <= 1'b1;
    ev(1'b1, 5'h00, 6'h00);
    wake(900, 1'b1);
    ev(1'b1, 5'h00, 6'h20);
    wr(`FEM_MODE_OFS, 32'h1, `FEM_RESP_OKAY);
    wake(900, 1'b0);
    wr(`FEM_MODE_OFS, 32'h4, `FEM_RESP_OKAY);
    wt(6);
    chk({31'h0, ldo3_on}, 32'h0);
    wr(`FEM_MODE_OFS, 32'h0, `FEM_RESP_OKAY);
    wt(6);
    chk({31'h0, ldo3_on}, 32'h1);
    die_above_165 <= 1'b1;
    wt(8);
    chk(pins, pe(1'b0, 1'b0, 1'b0, 2'h1));
    rd(`FEM_STATUS_OFS, st(1'b0, 5'h10));
    rd(`FEM_INTERRUPT_OFS, 32'h10);
    wr(`FEM_MODE_OFS, 32'h2, `FEM_RESP_OKAY);
    die_above_165 <= 1'b0;
    wt(12);
    rd(`FEM_MODE_OFS, {29'h0, `FEM_MODE_RST});
    chk(pins, pe(1'b1, 1'b1, 1'b1, 2'h1));
    rail_5v_ok <= 1'b0;
    wt(8);
    chk({31'h0, driver_en}, 32'h0);
    rail_5v_ok <= 1'b1;
    internal_5v_used <= 1'b0;
    wr(`FEM_MODE_OFS, 32'h2, `FEM_RESP_OKAY);
    die_above_165 <= 1'b1;
    wt(8);
    rd(`FEM_INTERRUPT_OFS, 32'h10);
    die_above_165 <= 1'b0;
    wt(12);
    rd(`FEM_MODE_OFS, 32'h2);
    chk(pins, pe(1'b1, 1'b1, 1'b1, 2'h1));
    tally_and_finish;
  end
endmodule
